// [src/dca_pkg.sv]
// Constants, field layout and state type of the two-channel transfer engine
// Behaviour
// - Mode bits 5:3 = 010/011 give memory-to-peripheral, memory address up/down.
// - Mode bits 5:3 = 100/101 give peripheral-to-memory, memory address up/down.
// - Mode bits 5:3 = 000/001 give memory-to-memory, both addresses moving together.
// - Writing a base register loads the matching current register simultaneously.
// - Peripheral transfers keep the port address fixed, step only memory address.
// - Memory-to-peripheral: ack, latch high, port address, io write; then latch low, memory read.
// - Peripheral-to-memory: ack, latch high, port address, io read; then latch low, memory write.
// - Peripheral transfers start only from the channel request pin, single or demand.
// - Memory-to-memory ignores polarity, request mode and auto-initialise; software writes bit 0 zero.
// - Memory-to-memory starts only when software writes command bit 5 set.
// - Memory-to-memory keeps the bus until terminal count, except a non-maskable abort or an external master set above the channels.
// - Memory-to-memory reads at port address, holds the byte, writes at memory address.
// - For peripheral types command bit 5 one enables, zero disables the channel.
// - Any write to an enabled channel's register other than the command register disables it; reads never disable it.
// - Single or software requests for a disabled channel are dropped, not remembered.
// - Channel 1 beats channel 0; channel 0 resumes when channel 1 request drops.
// - External master requests on active-low level input, granted on active-low output.
// - Control bits 4:3: 11 external above channels, 10 below; bit 4 zero means none.
// - External top: suspend channel after current byte, serve master, then pending channels.
// - External bottom: grant only after channel work ends; later requests wait for master.
// - Once granted, the bus stays with the external master until it drops its request.
// - Control bit 2 one enables abort on non-maskable interrupt, zero disables it.
// - Mode bit 1: zero single byte per request edge, one demand while level holds.
// - Mode bit 2: zero falling edge or low level, one rising edge or high level.
// - Count reaching zero raises terminal count and status bit 0, cleared by status read.
package dca_pkg;
   localparam int ADDR_W = 16;
   localparam int CNT_W = 16;
   localparam int DATA_W = 8;
   localparam int APB_AW = 8;
   localparam int NCH = 2;
   // Register map: per channel block, channel 1 at CH_STRIDE
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_CMD = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam logic [7:0] OFS_BPORT = 8'h0c;
   localparam logic [7:0] OFS_BMEM = 8'h10;
   localparam logic [7:0] OFS_BCNT = 8'h14;
   localparam logic [7:0] OFS_CPORT = 8'h18;
   localparam logic [7:0] OFS_CMEM = 8'h1c;
   localparam logic [7:0] CH_STRIDE = 8'h20;
   localparam logic [7:0] LOC_MASK = 8'h1f;
   localparam int CH_BIT = 5;
   localparam logic [7:0] OFS_CTRL = 8'h40;
   localparam logic [7:0] OFS_CCNT0 = 8'h48;
   localparam logic [7:0] OFS_CCNT1 = 8'h4c;
   localparam logic [7:0] OFS_NMICLR = 8'h44;
   // Field positions
   localparam int MODE_AUTO = 0;
   localparam int MODE_DEMAND = 1;
   localparam int MODE_POL = 2;
   localparam int MODE_DEC = 3;
   localparam int MODE_TYPE_LO = 4;
   localparam int MODE_TYPE_HI = 5;
   localparam int CMD_EN = 5;
   localparam int STAT_TC = 0;
   localparam int CTRL_NMI = 2;
   localparam int CTRL_EXTPRI = 3;
   localparam int CTRL_EXTON = 4;
   // Transfer type encodings of mode bits 5:4
   localparam logic [1:0] TYPE_M2M = 2'h0;
   localparam logic [1:0] TYPE_M2IO = 2'h1;
   localparam logic [1:0] TYPE_IO2M = 2'h2;
   // Reset values
   localparam logic [7:0] REG8_RST = 8'h00;
   localparam logic [15:0] REG16_RST = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam logic [ADDR_W-1:0] ADDR_ONE = 16'h0001;
   localparam logic [ADDR_W-1:0] ADDR_IDLE = 16'h0000;
   // Synchroniser order {nmiN, cpuBusAckN, extBusRequestN, dmaRequest[1:0]}
   localparam int SYN_W = 5;
   localparam logic [SYN_W-1:0] SYN_RST = 5'h1c;
   localparam int SYN_EXT = 2;
   localparam int SYN_ACK = 3;
   localparam int SYN_NMI = 4;
   typedef enum logic [3:0] {
      ST_IDLE, ST_BUSREQ, ST_ARB, ST_S1, ST_S2, ST_S3, ST_S4, ST_EXTG, ST_REL
   } dca_state_e;
endpackage : dca_pkg

// [src/dca_engine.sv]
// Two-channel byte transfer engine with APB registers and bus arbitration
`timescale 1ns/100ps
module dca_engine (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [dca_pkg::APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Channel pins
   input wire logic [dca_pkg::NCH-1:0] dmaRequest,
   output logic [dca_pkg::NCH-1:0] dmaAckN,
   output logic [dca_pkg::NCH-1:0] terminalCount,
   // System bus strobes, address and data
   output logic portAddrLatch,
   output logic ioWriteN,
   output logic ioReadN,
   output logic memReadN,
   output logic memWriteN,
   output logic [dca_pkg::ADDR_W-1:0] addrBus,
   input wire logic [dca_pkg::DATA_W-1:0] dataIn,
   output logic [dca_pkg::DATA_W-1:0] dataOut,
   output logic dataOe,
   // Processor bus handshake
   output logic cpuBusRequestN,
   input wire logic cpuBusAckN,
   // External master and abort input
   input wire logic extBusRequestN,
   output logic extBusGrantN,
   input wire logic nmiN
);
   import dca_pkg::*;
   logic [7:0] modeFf [NCH];
   logic [7:0] ctrlFf;
   logic [ADDR_W-1:0] basePortFf [NCH];
   logic [ADDR_W-1:0] baseMemFf [NCH];
   logic [CNT_W-1:0] baseCntFf [NCH];
   logic [ADDR_W-1:0] curPortFf [NCH];
   logic [ADDR_W-1:0] curMemFf [NCH];
   logic [CNT_W-1:0] curCntFf [NCH];
   logic [NCH-1:0] enFf, pendFf, tcFlagFf, reqPrevFf;
   logic [SYN_W-1:0] syn1Ff, syn2Ff, syn3Ff, stableFf;
   logic nmiPrevFf, nmiFlagFf, chFf, nxt_ch;
   dca_state_e stateFf, nxt_state;
   logic [NCH-1:0] reqLvl, levelOn, edgeOn, isM2m, isPer, want;
   logic extReq, extOn, extTop, apbWr, apbRd, chanHit, wrCh;
   logic [7:0] locOfs;
   logic [1:0] actType;
   // Step an address by one in the chosen direction
   function automatic logic [ADDR_W-1:0] stepAddr(input logic [ADDR_W-1:0] a, input logic dec);
      stepAddr = dec ? a - ADDR_ONE : a + ADDR_ONE;
   endfunction : stepAddr
   // Three-stage synchroniser; value accepted once stages two and three agree
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         syn1Ff <= SYN_RST;
         syn2Ff <= SYN_RST;
         syn3Ff <= SYN_RST;
         stableFf <= SYN_RST;
      end else begin
         syn1Ff <= {nmiN, cpuBusAckN, extBusRequestN, dmaRequest};
         syn2Ff <= syn1Ff;
         syn3Ff <= syn2Ff;
         stableFf <= (syn2Ff & ~(syn2Ff ^ syn3Ff)) | (stableFf & (syn2Ff ^ syn3Ff));
      end
   end
   // Previous levels for edge detection
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reqPrevFf <= SYN_RST[NCH-1:0];
         nmiPrevFf <= SYN_RST[SYN_NMI];
      end else begin
         reqPrevFf <= reqLvl;
         nmiPrevFf <= stableFf[SYN_NMI];
      end
   end
   // Request qualification per channel
   always_comb begin
      reqLvl = stableFf[NCH-1:0];
      extReq = ~stableFf[SYN_EXT];
      extOn = ctrlFf[CTRL_EXTON];
      extTop = ctrlFf[CTRL_EXTON] & ctrlFf[CTRL_EXTPRI];
      for (int c = 0; c < NCH; c++) begin
         levelOn[c] = modeFf[c][MODE_POL] ? reqLvl[c] : ~reqLvl[c];
         edgeOn[c] = modeFf[c][MODE_POL] ? (reqLvl[c] & ~reqPrevFf[c])
            : (~reqLvl[c] & reqPrevFf[c]);
         isM2m[c] = modeFf[c][MODE_TYPE_HI:MODE_TYPE_LO] == TYPE_M2M;
         isPer[c] = (modeFf[c][MODE_TYPE_HI:MODE_TYPE_LO] == TYPE_M2IO)
            | (modeFf[c][MODE_TYPE_HI:MODE_TYPE_LO] == TYPE_IO2M);
         // Memory-to-memory runs on enable alone, pin and mode bits ignored
         want[c] = enFf[c] & (isM2m[c]
            | (isPer[c] & (modeFf[c][MODE_DEMAND] ? levelOn[c] : pendFf[c])));
      end
   end
   // APB decode
   always_comb begin
      apbWr = psel & penable & pwrite & pready;
      apbRd = psel & penable & ~pwrite & pready;
      chanHit = paddr < OFS_CTRL;
      wrCh = paddr[CH_BIT];
      locOfs = paddr & LOC_MASK;
      actType = modeFf[chFf][MODE_TYPE_HI:MODE_TYPE_LO];
   end
   // Transfer sequencer next state
   always_comb begin
      nxt_state = stateFf;
      nxt_ch = chFf;
      case (stateFf)
         ST_IDLE: begin
            if (((|want) & ~nmiFlagFf) | (extOn & extReq)) begin
               nxt_state = ST_BUSREQ;
            end
         end
         ST_BUSREQ: begin
            if (~stableFf[SYN_ACK]) begin
               nxt_state = ST_ARB;
            end
         end
         ST_ARB: begin
            if (extTop & extReq) begin
               nxt_state = ST_EXTG;
            end else if (nmiFlagFf) begin
               nxt_state = ST_REL;
            end else if (want[1]) begin
               nxt_state = ST_S1;
               nxt_ch = 1'b1;
            end else if (want[0]) begin
               nxt_state = ST_S1;
               nxt_ch = 1'b0;
            end else if (extOn & extReq) begin
               nxt_state = ST_EXTG;
            end else begin
               nxt_state = ST_REL;
            end
         end
         ST_S1: nxt_state = ST_S2;
         ST_S2: nxt_state = ST_S3;
         ST_S3: nxt_state = (curCntFf[chFf] == CNT_ONE) ? ST_S4 : ST_ARB;
         ST_S4: nxt_state = ST_ARB;
         ST_EXTG: begin
            if (~extReq) begin
               nxt_state = ST_ARB;
            end
         end
         ST_REL: begin
            if (stableFf[SYN_ACK]) begin
               nxt_state = ST_IDLE;
            end
         end
         default: nxt_state = ST_IDLE;
      endcase
   end
   // State and active channel
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stateFf <= ST_IDLE;
         chFf <= 1'b0;
      end else begin
         stateFf <= nxt_state;
         chFf <= nxt_ch;
      end
   end
   // Global control and abort flag; a new abort edge wins over its clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrlFf <= REG8_RST;
         nmiFlagFf <= 1'b0;
      end else begin
         if (apbWr && paddr == OFS_CTRL) begin
            ctrlFf <= pwdata[7:0];
         end
         if (ctrlFf[CTRL_NMI] & nmiPrevFf & ~stableFf[SYN_NMI]) begin
            nmiFlagFf <= 1'b1;
         end else if (apbWr && paddr == OFS_NMICLR) begin
            nmiFlagFf <= 1'b0;
         end
      end
   end
   // Channel registers, enable, pending request and terminal count flag
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int c = 0; c < NCH; c++) begin
            modeFf[c] <= REG8_RST;
            basePortFf[c] <= REG16_RST;
            baseMemFf[c] <= REG16_RST;
            baseCntFf[c] <= REG16_RST;
            curPortFf[c] <= REG16_RST;
            curMemFf[c] <= REG16_RST;
            curCntFf[c] <= REG16_RST;
         end
         enFf <= '0;
         pendFf <= '0;
         tcFlagFf <= '0;
      end else begin
         for (int c = 0; c < NCH; c++) begin
            // Byte completion: count down, step addresses
            if (stateFf == ST_S3 && chFf == 1'(c)) begin
               curCntFf[c] <= curCntFf[c] - CNT_ONE;
               curMemFf[c] <= stepAddr(curMemFf[c], modeFf[c][MODE_DEC]);
               if (isM2m[c]) begin
                  curPortFf[c] <= stepAddr(curPortFf[c], modeFf[c][MODE_DEC]);
               end
               if (curCntFf[c] == CNT_ONE && !(isPer[c] && modeFf[c][MODE_AUTO])) begin
                  enFf[c] <= 1'b0;
               end
            end
            // Auto-initialise reload on terminal count, peripheral types only
            if (stateFf == ST_S4 && chFf == 1'(c) && isPer[c] && modeFf[c][MODE_AUTO]) begin
               curPortFf[c] <= basePortFf[c];
               curMemFf[c] <= baseMemFf[c];
               curCntFf[c] <= baseCntFf[c];
            end
            // Single request: remembered only while enabled
            if (nxt_state == ST_S1 && stateFf != ST_S1 && nxt_ch == 1'(c)) begin
               pendFf[c] <= 1'b0;
            end
            if (!enFf[c]) begin
               pendFf[c] <= 1'b0;
            end
            if (enFf[c] && isPer[c] && !modeFf[c][MODE_DEMAND] && edgeOn[c]) begin
               pendFf[c] <= 1'b1;
            end
            // Software writes; they take precedence over byte updates
            if (apbWr && chanHit && wrCh == 1'(c)) begin
               if (locOfs != OFS_CMD) begin
                  enFf[c] <= 1'b0;
               end
               if (locOfs == OFS_MODE) begin
                  modeFf[c] <= pwdata[7:0];
               end else if (locOfs == OFS_CMD) begin
                  enFf[c] <= pwdata[CMD_EN];
               end else if (locOfs == OFS_BPORT) begin
                  basePortFf[c] <= pwdata[ADDR_W-1:0];
                  curPortFf[c] <= pwdata[ADDR_W-1:0];
               end else if (locOfs == OFS_BMEM) begin
                  baseMemFf[c] <= pwdata[ADDR_W-1:0];
                  curMemFf[c] <= pwdata[ADDR_W-1:0];
               end else if (locOfs == OFS_BCNT) begin
                  baseCntFf[c] <= pwdata[CNT_W-1:0];
                  curCntFf[c] <= pwdata[CNT_W-1:0];
               end
            end
            // Terminal count flag: set beats clear by status read or write
            if (stateFf == ST_S3 && chFf == 1'(c) && curCntFf[c] == CNT_ONE) begin
               tcFlagFf[c] <= 1'b1;
            end else if (chanHit && wrCh == 1'(c) && (apbWr || (apbRd && locOfs == OFS_STAT))) begin
               tcFlagFf[c] <= 1'b0;
            end
         end
      end
   end
   // Bus pins, registered from the next state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dmaAckN <= '1;
         terminalCount <= '0;
         portAddrLatch <= 1'b0;
         ioWriteN <= 1'b1;
         ioReadN <= 1'b1;
         memReadN <= 1'b1;
         memWriteN <= 1'b1;
         addrBus <= ADDR_IDLE;
         dataOe <= 1'b0;
         cpuBusRequestN <= 1'b1;
         extBusGrantN <= 1'b1;
      end else begin
         dmaAckN <= '1;
         terminalCount <= '0;
         portAddrLatch <= 1'b0;
         ioWriteN <= 1'b1;
         ioReadN <= 1'b1;
         memReadN <= 1'b1;
         memWriteN <= 1'b1;
         addrBus <= ADDR_IDLE;
         dataOe <= 1'b0;
         cpuBusRequestN <= ~(nxt_state != ST_IDLE && nxt_state != ST_REL);
         extBusGrantN <= ~(nxt_state == ST_EXTG);
         if (nxt_state == ST_S1 || nxt_state == ST_S2 || nxt_state == ST_S3
               || nxt_state == ST_S4) begin
            dmaAckN[nxt_ch] <= 1'b0;
         end
         if (nxt_state == ST_S4) begin
            terminalCount[nxt_ch] <= 1'b1;
         end
         if (nxt_state == ST_S2) begin
            addrBus <= curPortFf[nxt_ch];
            if (isM2m[nxt_ch]) begin
               memReadN <= 1'b0;
            end else begin
               portAddrLatch <= 1'b1;
               ioWriteN <= ~(modeFf[nxt_ch][MODE_TYPE_HI:MODE_TYPE_LO] == TYPE_M2IO);
               ioReadN <= ~(modeFf[nxt_ch][MODE_TYPE_HI:MODE_TYPE_LO] == TYPE_IO2M);
            end
         end
         if (nxt_state == ST_S3) begin
            addrBus <= curMemFf[nxt_ch];
            if (actType == TYPE_M2M) begin
               memWriteN <= 1'b0;
               dataOe <= 1'b1;
            end else if (actType == TYPE_M2IO) begin
               ioWriteN <= 1'b0;
               memReadN <= 1'b0;
            end else begin
               ioReadN <= 1'b0;
               memWriteN <= 1'b0;
            end
         end
      end
   end
   // Held byte for memory-to-memory, captured at the end of the read phase
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dataOut <= REG8_RST;
      end else if (stateFf == ST_S2 && isM2m[chFf]) begin
         dataOut <= dataIn;
      end
   end
   // APB answer: data prepared in setup, ready in the single access cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= 1'b0;
         prdata <= '0;
         if (psel && !penable) begin
            if (chanHit) begin
               if (locOfs == OFS_MODE) begin
                  prdata <= {24'h000000, modeFf[wrCh]};
               end else if (locOfs == OFS_CMD) begin
                  prdata <= 32'(enFf[wrCh]) << CMD_EN;
               end else if (locOfs == OFS_STAT) begin
                  prdata <= 32'(tcFlagFf[wrCh]) << STAT_TC;
               end else if (locOfs == OFS_BPORT) begin
                  prdata <= {16'h0000, basePortFf[wrCh]};
               end else if (locOfs == OFS_BMEM) begin
                  prdata <= {16'h0000, baseMemFf[wrCh]};
               end else if (locOfs == OFS_BCNT) begin
                  prdata <= {16'h0000, baseCntFf[wrCh]};
               end else if (locOfs == OFS_CPORT) begin
                  prdata <= {16'h0000, curPortFf[wrCh]};
               end else if (locOfs == OFS_CMEM) begin
                  prdata <= {16'h0000, curMemFf[wrCh]};
               end else begin
                  pslverr <= 1'b1;
               end
            end else if (paddr == OFS_CTRL) begin
               prdata <= {24'h000000, ctrlFf};
            end else if (paddr == OFS_CCNT0) begin
               prdata <= {16'h0000, curCntFf[0]};
            end else if (paddr == OFS_CCNT1) begin
               prdata <= {16'h0000, curCntFf[1]};
            end else if (paddr == OFS_NMICLR) begin
               prdata <= 32'(nmiFlagFf);
            end else begin
               pslverr <= 1'b1;
            end
         end
      end
   end
endmodule : dca_engine

// [tb/dca_chk.sv]
// Checker of strobe order, grant and count pulses
`timescale 1ns/100ps
module dca_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Watched pins
   input wire logic [dca_pkg::NCH-1:0] dmaAckN,
   input wire logic [dca_pkg::NCH-1:0] terminalCount,
   input wire logic portAddrLatch,
   input wire logic ioWriteN,
   input wire logic ioReadN,
   input wire logic memReadN,
   input wire logic memWriteN,
   input wire logic [dca_pkg::DATA_W-1:0] dataIn,
   input wire logic [dca_pkg::DATA_W-1:0] dataOut,
   input wire logic dataOe,
   input wire logic cpuBusRequestN,
   input wire logic extBusRequestN,
   input wire logic extBusGrantN
);
   import dca_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Port phase, then memory phase of one peripheral byte
   sequence portPh(ioN);
      portAddrLatch && !ioN;
   endsequence
   sequence memPh(ioN, memN);
      !portAddrLatch && !ioN && !memN;
   endsequence
   a_m2io_order: assert property (portPh(ioWriteN) |=> memPh(ioWriteN, memReadN))
      else $error("memory read phase missing");
   a_io2m_order: assert property (portPh(ioReadN) |=> memPh(ioReadN, memWriteN))
      else $error("memory write phase missing");
   a_ack_first: assert property ($rose(portAddrLatch) |-> $past(dmaAckN) != 2'b11)
      else $error("latch rose without acknowledge");
   a_one_chan: assert property (dmaAckN != 2'b00)
      else $error("both channels acknowledged");
   a_m2m_hold: assert property (!memReadN && ioReadN && ioWriteN |=>
      !memWriteN && dataOe && dataOut == $past(dataIn)) else $error("held byte lost");
   a_grant_keep: assert property (!extBusGrantN && !extBusRequestN |=> !extBusGrantN)
      else $error("grant dropped early");
   a_grant_quiet: assert property (!extBusGrantN |-> dmaAckN == 2'b11 && memReadN &&
      memWriteN && ioReadN && ioWriteN) else $error("strobe during grant");
   a_count_pulse: assert property (terminalCount != 2'b00 |->
      (terminalCount & dmaAckN) == 2'b00 ##1 terminalCount == 2'b00) else $error("count pulse");
   a_bus_owned: assert property (dmaAckN != 2'b11 |-> !cpuBusRequestN)
      else $error("acknowledge without bus request");
endmodule : dca_chk
bind dca_engine dca_chk i_dca_chk (.*);

// [tb/dca_bus_model.sv]
// Processor bus handover and memory read data
`timescale 1ns/100ps
module dca_bus_model #(parameter int ACK_DLY = 2) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // System bus
   input wire logic cpuBusRequestN,
   input wire logic memReadN,
   input wire logic [dca_pkg::ADDR_W-1:0] addrBus,
   output logic cpuBusAckN,
   output logic [dca_pkg::DATA_W-1:0] dataIn
);
   import dca_pkg::*;
   logic [ACK_DLY-1:0] ackPipe_ff;
   logic [DATA_W-1:0] junk_ff;
   // Processor gives the bus up and takes it back after a delay
   always_ff @(posedge clk or posedge rst) begin
      if (rst) ackPipe_ff <= '1;
      else ackPipe_ff <= {ackPipe_ff[ACK_DLY-2:0], cpuBusRequestN};
   end
   // Undriven data lines wander every cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) junk_ff <= '0;
      else junk_ff <= junk_ff + 8'h3b;
   end
   assign cpuBusAckN = ackPipe_ff[ACK_DLY-1];
   assign dataIn = memReadN ? junk_ff : addrBus[7:0] ^ 8'h5a;
endmodule : dca_bus_model

// [tb/dca_engine_tb_top.sv]
// Register-level tests of the transfer engine
`timescale 1ns/100ps
`define CHK(n, x, y) begin totalChecks++; if ((y) !== (x)) begin failures++; \
   $display("BAD %s exp %0h got %0h", n, x, y); end end
module dca_engine_tb_top;
   import dca_pkg::*;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, err, portAddrLatch, ioWriteN;
   logic ioReadN, memReadN, memWriteN, dataOe, cpuBusRequestN, cpuBusAckN, extBusRequestN;
   logic extBusGrantN, nmiN;
   logic [APB_AW-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [NCH-1:0] dmaRequest, dmaAckN, terminalCount;
   logic [ADDR_W-1:0] addrBus;
   logic [DATA_W-1:0] dataIn, dataOut;
   logic [15:0] rdQ[$], wrQ[$], ltQ[$];
   logic [7:0] wdQ[$];
   int failures = 0;
   int totalChecks = 0;
   int n;
   dca_engine i_dca_engine (.*);
   dca_bus_model i_dca_bus_model (.*);
   // Free-running clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Log strobe cycles on the system bus
   always @(posedge clk) begin
      if (portAddrLatch) ltQ.push_back(addrBus);
      if (!memReadN) rdQ.push_back(addrBus);
      if (!memWriteN) wrQ.push_back(addrBus);
      if (!memWriteN) wdQ.push_back(dataOut);
   end
   // One APB transfer, read data and error kept
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d = 0);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Mode and base registers of one channel
   task automatic setup(input int ch, input logic [7:0] m, input logic [15:0] p, a, c);
      logic [7:0] b;
      b = ch ? CH_STRIDE : 8'h00;
      apb(1'b1, b + OFS_MODE, {24'h0, m});
      apb(1'b1, b + OFS_BPORT, {16'h0, p});
      apb(1'b1, b + OFS_BMEM, {16'h0, a});
      apb(1'b1, b + OFS_BCNT, {16'h0, c});
   endtask : setup
   task automatic clr();
      rdQ.delete();
      wrQ.delete();
      ltQ.delete();
      wdQ.delete();
   endtask : clr
   // Until the count pulse and the bus is handed back
   task automatic waitDone(input int ch);
      while (terminalCount[ch] !== 1'b1) @(posedge clk);
      while (cpuBusRequestN !== 1'b1) @(posedge clk);
   endtask : waitDone
   task automatic chkSeq(input string nm, input logic [15:0] q[$], input logic [15:0] b, s,
                         input int c);
      logic [15:0] e;
      `CHK(nm, c, q.size())
      for (int i = 0; i < c; i++) begin
         e = 16'(b + s * i);
         `CHK(nm, e, q[i])
      end
   endtask : chkSeq
   task automatic stop_test();
      $display("checks %0d failures %0d", totalChecks, failures);
      if (failures == 0 && totalChecks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   // Watchdog
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      stop_test();
   end
   // Test sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata} <= '0;
      dmaRequest <= 2'b01;
      extBusRequestN <= 1'b1;
      nmiN <= 1'b1;
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      `CHK("busreq", 1'b1, cpuBusRequestN)
      setup(0, 8'h00, 16'h0100, 16'h0200, 16'h0003);
      apb(1'b0, OFS_CPORT);
      `CHK("cport", 32'h0100, rd)
      apb(1'b0, 8'h7c);
      `CHK("unmapped", 1'b1, err)
      clr();
      apb(1'b1, OFS_CMD, 32'h20);
      waitDone(0);
      chkSeq("m2m rd", rdQ, 16'h0100, 16'h0001, 3);
      chkSeq("m2m wr", wrQ, 16'h0200, 16'h0001, 3);
      for (int i = 0; i < 3; i++) `CHK("m2m data", 8'h5a ^ 8'(i), wdQ[i])
      apb(1'b0, OFS_STAT);
      `CHK("flag set", 32'h1, rd)
      apb(1'b0, OFS_STAT);
      `CHK("flag clear", 32'h0, rd)
      // Channel 1 memory to io, decrement, demand on high level
      setup(1, 8'h1e, 16'h0040, 16'h0300, 16'h0002);
      clr();
      dmaRequest[1] <= 1'b1;
      repeat (20) @(posedge clk);
      `CHK("disabled", 0, rdQ.size())
      apb(1'b1, CH_STRIDE + OFS_CMD, 32'h20);
      waitDone(1);
      dmaRequest[1] <= 1'b0;
      chkSeq("m2io rd", rdQ, 16'h0300, 16'hffff, 2);
      chkSeq("m2io port", ltQ, 16'h0040, 16'h0000, 2);
      // Channel 0 io to memory, single falling edge
      setup(0, 8'h20, 16'h0050, 16'h0500, 16'h0001);
      apb(1'b1, OFS_CMD, 32'h20);
      apb(1'b1, OFS_BMEM, 32'h0500);
      clr();
      dmaRequest[0] <= 1'b0;
      repeat (20) @(posedge clk);
      `CHK("dropped", 0, wrQ.size())
      dmaRequest[0] <= 1'b1;
      apb(1'b1, OFS_CMD, 32'h20);
      apb(1'b0, OFS_STAT);
      dmaRequest[0] <= 1'b0;
      waitDone(0);
      chkSeq("io2m wr", wrQ, 16'h0500, 16'h0000, 1);
      chkSeq("io2m port", ltQ, 16'h0050, 16'h0000, 1);
      // External master on top interrupts memory to memory
      setup(0, 8'h00, 16'h0100, 16'h0600, 16'h0006);
      apb(1'b1, OFS_CTRL, 32'h18);
      clr();
      apb(1'b1, OFS_CMD, 32'h20);
      while (wrQ.size() == 0) @(posedge clk);
      extBusRequestN <= 1'b0;
      while (extBusGrantN !== 1'b0) @(posedge clk);
      n = wrQ.size();
      `CHK("suspended", 1'b1, n < 6)
      repeat (10) @(posedge clk);
      `CHK("held", n, wrQ.size())
      extBusRequestN <= 1'b1;
      waitDone(0);
      chkSeq("resumed", wrQ, 16'h0600, 16'h0001, 6);
      // Abort on non-maskable interrupt releases the bus, clearing resumes
      setup(0, 8'h00, 16'h0100, 16'h0700, 16'h0005);
      apb(1'b1, OFS_CTRL, 32'h04);
      clr();
      apb(1'b1, OFS_CMD, 32'h20);
      while (wrQ.size() == 0) @(posedge clk);
      nmiN <= 1'b0;
      while (cpuBusRequestN !== 1'b1) @(posedge clk);
      n = wrQ.size();
      `CHK("aborted", 1'b1, n < 5)
      repeat (10) @(posedge clk);
      `CHK("abort held", n, wrQ.size())
      nmiN <= 1'b1;
      apb(1'b1, OFS_NMICLR);
      waitDone(0);
      chkSeq("abort resumed", wrQ, 16'h0700, 16'h0001, 5);
      stop_test();
   end
endmodule : dca_engine_tb_top
